/* File: verilog/crb_rx_buffering.sv */
// can receive buffering: two-stage receive queue, transmit buffers and wishbone registers
//
// Behaviour
// - transmit pin low dominant, high recessive
// - frames of zero to eight data bytes
// - bit rate capped at one megabit
// - receive queue two messages deep
// - only foreground buffer visible to cpu
// - each buffer thirteen bytes long
// - full flag marks accepted foreground message
// - capture into background while filtering
// - background overwritten by every frame unless a message waits there
// - copy to foreground only while empty
// - receive interrupt on full unless masked
// - ready again right after interframe space
// - own frames stay in background only
// - loop-back treats own frames normally
// - lost arbitration turns node into receiver
// - third accepted message dropped, overrun flagged
// - transmit still works while queue full
// - three transmit buffers
`timescale 1ns/100ps
`include "crb_defines.svh"

module crb_rx_buffering
   import crb_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [8:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   // bus pins
   input  wire logic        i_bus_receive_pin,
   output logic             o_bus_transmit_pin,
   // protocol engine, receive side
   input  wire logic        i_rx_sof,
   input  wire logic        i_rx_wr,
   input  wire crb_idx_t    i_rx_idx,
   input  wire crb_byte_t   i_rx_data,
   input  wire logic        i_rx_eof_ok,
   input  wire logic        i_filter_hit,
   input  wire logic        i_transmitting,
   input  wire logic        i_arb_lost,
   output logic             o_rx_level,
   output logic             o_ack_allowed,
   output logic             o_bit_tick,
   // protocol engine, transmit side
   input  wire logic        i_tx_level,
   input  wire crb_idx_t    i_tx_rd_idx,
   input  wire logic        i_tx_done,
   output logic             o_tx_req,
   output logic [1:0]       o_tx_sel,
   output crb_byte_t        o_tx_byte,
   // interrupt lines
   output logic             o_rx_irq,
   output logic             o_ovr_irq
);

   // ------------------------------------------------------------
   // pin synchroniser and transmit pin
   logic       rx_meta_q;
   logic       rx_sync_q;
   logic       tx_pin_q;

   // receive pin passes two flops; transmit pin resets recessive
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         tx_pin_q  <= 1'b1;
      end else begin
         rx_meta_q <= i_bus_receive_pin;
         rx_sync_q <= rx_meta_q;
         tx_pin_q  <= i_tx_level;
      end
   end

   // synced level and registered pin out
   assign o_rx_level         = rx_sync_q;
   assign o_bus_transmit_pin = tx_pin_q;

   // ------------------------------------------------------------
   // wishbone decode
   logic        req;
   logic        wr_stb;
   logic        rd_stb;
   logic [8:0]  adr_w;
   logic [2:0]  blk;
   crb_idx_t    widx;
   logic        hit_ctrl;
   logic        hit_flag;
   logic        hit_div;
   logic        hit_txf;
   logic        hit_rxwin;
   logic        hit_txb;
   logic [1:0]  txb_num;
   logic        ack_q;

   // one request per ack, then address decode
   assign req       = i_wb_cyc && i_wb_stb && !ack_q;
   assign wr_stb    = req && i_wb_we;
   assign rd_stb    = req && !i_wb_we;
   assign adr_w     = {i_wb_adr[8:2], 2'b00};
   assign blk       = i_wb_adr[8:6];
   assign widx      = i_wb_adr[5:2];
   assign hit_ctrl  = (adr_w == `CRB_ADR_CTRL);
   assign hit_flag  = (adr_w == `CRB_ADR_FLAG);
   assign hit_div   = (adr_w == `CRB_ADR_BITDIV);
   assign hit_txf   = (adr_w == `CRB_ADR_TXFLAG);
   assign hit_rxwin = (blk == `CRB_ADR_RXWIN_BLK) && (widx < 4'(`CRB_BUF_BYTES));
   assign hit_txb   = (blk >= `CRB_ADR_TX0_BLK)
                    && (blk < `CRB_ADR_TX0_BLK + 3'(`CRB_TX_BUFS))
                    && (widx < 4'(`CRB_BUF_BYTES));
   assign txb_num   = 2'(blk - `CRB_ADR_TX0_BLK);

   // ------------------------------------------------------------
   // software registers
   logic        loopback_q;
   logic        rxie_q;
   logic        ovrie_q;
   logic [15:0] div_q;

   // control and divider writes honour byte lanes
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         loopback_q <= 1'b0;
         rxie_q     <= 1'b0;
         ovrie_q    <= 1'b0;
         div_q      <= `CRB_DIV_RESET;
      end else begin
         if (wr_stb && hit_ctrl && i_wb_sel[0]) begin
            loopback_q <= i_wb_dat[`CRB_CTRL_LOOPBACK];
            rxie_q     <= i_wb_dat[`CRB_CTRL_RXIE];
            ovrie_q    <= i_wb_dat[`CRB_CTRL_OVRIE];
         end
         if (wr_stb && hit_div && i_wb_sel[0]) begin
            div_q[7:0] <= i_wb_dat[7:0];
         end
         if (wr_stb && hit_div && i_wb_sel[1]) begin
            div_q[15:8] <= i_wb_dat[15:8];
         end
      end
   end

   // bit rate enable
   crb_bit_rate u_bit_rate (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_div   (div_q),
      .o_tick  (o_bit_tick)
   );

   // ------------------------------------------------------------
   // own frame tracking
   logic own_q;

   // frame starts as own while transmitting; losing arbitration drops it
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         own_q <= 1'b0;
      end else if (i_arb_lost) begin
         own_q <= 1'b0;
      end else if (i_rx_sof) begin
         own_q <= i_transmitting;
      end
   end

   logic own_now;
   logic own_blocked;

   // own status of the frame now being received
   assign own_now       = i_rx_sof ? i_transmitting : (own_q && !i_arb_lost);
   assign own_blocked   = own_now && !loopback_q;
   assign o_ack_allowed = !own_blocked;

   // ------------------------------------------------------------
   // background stage
   logic       bg_pend_q;
   crb_frame_t bg_frame;

   crb_bg_buffer u_bg (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_wr    (i_rx_wr),
      .i_idx   (i_rx_idx),
      .i_data  (i_rx_data),
      .i_lock  (bg_pend_q),
      .o_frame (bg_frame)
   );

   // ------------------------------------------------------------
   // queue control
   logic       full_q;
   logic       ovr_q;
   logic       clr_full;
   logic       clr_ovr;
   logic       full_eff;
   logic       accepted;
   logic       promote;
   logic       copy_new;
   logic       park_new;
   logic       overrun;
   logic       copy_fg;
   logic       full_d;
   logic       pend_d;
   logic       ovr_d;

   assign clr_full = wr_stb && hit_flag && i_wb_sel[0] && i_wb_dat[`CRB_FLAG_RXF];
   assign clr_ovr  = wr_stb && hit_flag && i_wb_sel[0] && i_wb_dat[`CRB_FLAG_OVR];
   assign full_eff = full_q && !clr_full;

   // accepted frames are good, filtered and not a suppressed own frame
   assign accepted = i_rx_eof_ok && i_filter_hit && !own_blocked;
   assign promote  = clr_full && bg_pend_q;
   assign copy_new = accepted && !bg_pend_q && !full_eff;
   assign park_new = accepted && !bg_pend_q && full_eff;
   assign overrun  = accepted && bg_pend_q;
   assign copy_fg  = promote || copy_new;

   // next values of the queue flags
   assign full_d = copy_fg ? 1'b1 : full_eff;
   assign pend_d = park_new ? 1'b1 : (promote ? 1'b0 : bg_pend_q);
   assign ovr_d  = overrun ? 1'b1 : (ovr_q && !clr_ovr); // set wins

   // queue flags
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         full_q    <= 1'b0;
         bg_pend_q <= 1'b0;
         ovr_q     <= 1'b0;
      end else begin
         full_q    <= full_d;
         bg_pend_q <= pend_d;
         ovr_q     <= ovr_d;
      end
   end

   // foreground stage
   crb_frame_t fg_q;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fg_q <= '0;
      end else if (copy_fg) begin
         fg_q <= bg_frame;
      end
   end

   // interrupt lines gated by enables
   assign o_rx_irq  = full_q && rxie_q;
   assign o_ovr_irq = ovr_q && ovrie_q;

   // ------------------------------------------------------------
   // transmit buffers
   crb_byte_t  txb_q [`CRB_TX_BUFS][`CRB_BUF_BYTES];
   logic [2:0] txe_q;
   logic [2:0] txe_set;
   logic [2:0] txe_clr;
   logic [2:0] txe_d;
   logic [2:0] tx_ready;

   // lowest ready buffer goes first
   assign tx_ready = ~txe_q;
   assign o_tx_req = |tx_ready;
   assign o_tx_sel = tx_ready[0] ? 2'd0 : (tx_ready[1] ? 2'd1 : 2'd2);
   assign txe_clr  = (wr_stb && hit_txf && i_wb_sel[0]) ? i_wb_dat[2:0] : 3'b000;

   genvar g;
   generate
      for (g = 0; g < `CRB_TX_BUFS; g++) begin : g_txe
         // done marks the buffer empty again, and wins over a clear
         assign txe_set[g] = i_tx_done && o_tx_req && (o_tx_sel == 2'(g));
         assign txe_d[g]   = txe_set[g] || (txe_q[g] && !txe_clr[g]);
      end
   endgenerate

   // empty flags, all empty after reset
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         txe_q <= 3'b111;
      end else begin
         txe_q <= txe_d;
      end
   end

   // buffer array write port, no reset on storage
   always_ff @(posedge i_clk) begin
      if (wr_stb && hit_txb && i_wb_sel[0]) begin
         txb_q[txb_num][widx] <= i_wb_dat[7:0];
      end
   end

   // byte fetch for the engine, one cycle late
   crb_idx_t tx_idx_safe;

   assign tx_idx_safe = (i_tx_rd_idx < 4'(`CRB_BUF_BYTES)) ? i_tx_rd_idx : 4'h0;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tx_byte <= 8'h00;
      end else begin
         o_tx_byte <= txb_q[o_tx_sel][tx_idx_safe];
      end
   end

   // ------------------------------------------------------------
   // read mux
   logic [31:0] rd_mux;

   assign rd_mux = hit_ctrl  ? {29'h0, ovrie_q, rxie_q, loopback_q}
                 : hit_flag  ? {30'h0, ovr_q, full_q}
                 : hit_div   ? {16'h0, div_q}
                 : hit_txf   ? {29'h0, txe_q}
                 : hit_rxwin ? {24'h0, fg_q[widx]}
                 : hit_txb   ? {24'h0, txb_q[txb_num][widx]}
                 : 32'h0000_0000;

   // single-cycle acknowledge with registered data
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_q    <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         if (rd_stb) begin
            o_wb_dat <= rd_mux;
         end
      end
   end

   assign o_wb_ack = ack_q;

endmodule

/* File: verilog/crb_defines.svh */
// offsets, field positions, reset values and timing counts for the can receive buffering block
`ifndef CRB_DEFINES_SVH
`define CRB_DEFINES_SVH

// clock and bit rate limits
`define CRB_CLK_HZ            100000000
`define CRB_MAX_BIT_RATE_BPS  1000000
`define CRB_MIN_BIT_CYC       (`CRB_CLK_HZ / `CRB_MAX_BIT_RATE_BPS)
`define CRB_DIV_RESET         16'h01f4

// message buffer layout
`define CRB_BUF_BYTES         13
`define CRB_DLR_IDX           4'hc
`define CRB_MAX_DLC           4'h8

// register word byte addresses
`define CRB_ADR_CTRL          9'h000
`define CRB_ADR_FLAG          9'h004
`define CRB_ADR_BITDIV        9'h008
`define CRB_ADR_TXFLAG        9'h00c
`define CRB_ADR_RXWIN_BLK     3'h1
`define CRB_ADR_TX0_BLK       3'h2
`define CRB_TX_BUFS           3

// control register fields
`define CRB_CTRL_LOOPBACK     0
`define CRB_CTRL_RXIE         1
`define CRB_CTRL_OVRIE        2

// receiver flag register fields
`define CRB_FLAG_RXF          0
`define CRB_FLAG_OVR          1

`endif

/* File: verilog/crb_pkg.sv */
// shared types of the can receive buffering block
package crb_pkg;

   typedef logic [7:0]                crb_byte_t;
   typedef logic [12:0][7:0]          crb_frame_t;
   typedef logic [3:0]                crb_idx_t;

endpackage

/* File: verilog/crb_bit_rate.sv */
// bit rate divider producing a one-cycle bit enable
`timescale 1ns/100ps
`include "crb_defines.svh"

module crb_bit_rate
   import crb_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // configuration
   input  wire logic [15:0] i_div,
   // enable out
   output logic             o_tick
);

   localparam logic [15:0] MIN_DIV = 16'(`CRB_MIN_BIT_CYC);

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] div_eff;
   logic        wrap;

   // divider never runs faster than the top bit rate
   assign div_eff = (i_div < MIN_DIV) ? MIN_DIV : i_div;
   assign wrap    = (cnt_q >= div_eff - 16'h0001);
   assign cnt_d   = wrap ? 16'h0000 : cnt_q + 16'h0001;

   // free running count
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         o_tick <= wrap;
      end
   end

endmodule

/* File: verilog/crb_bg_buffer.sv */
// background receive buffer filled by the protocol engine
`timescale 1ns/100ps
`include "crb_defines.svh"

module crb_bg_buffer
   import crb_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   // byte writes from the protocol engine
   input  wire logic       i_wr,
   input  wire crb_idx_t   i_idx,
   input  wire crb_byte_t  i_data,
   // hold contents while a pending message waits
   input  wire logic       i_lock,
   // buffer contents
   output crb_frame_t      o_frame
);

   // data length code saturates at eight bytes
   function automatic crb_byte_t clamp_dlr(input crb_byte_t b);
      clamp_dlr = {b[7:4], (b[3:0] > `CRB_MAX_DLC) ? `CRB_MAX_DLC : b[3:0]};
   endfunction

   logic take;

   // every frame overwrites unless a pending one is held
   assign take = i_wr && !i_lock && (i_idx < 4'(`CRB_BUF_BYTES));

   // byte store
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_frame <= '0;
      end else if (take) begin
         if (i_idx == `CRB_DLR_IDX) begin
            o_frame[i_idx] <= clamp_dlr(i_data);
         end else begin
            o_frame[i_idx] <= i_data;
         end
      end
   end

endmodule

/* File: tb/crb_xcvr_model.sv */
// bus transceiver model: wired bus level fed back to the receive pin
`timescale 1ns/100ps
module crb_xcvr_model (
   // controller pins
   input  wire logic i_tx_pin,
   output logic      o_rx_pin,
   // another node driving dominant
   input  wire logic i_other_dom
);
   // low is dominant, any dominant driver wins
   assign o_rx_pin = i_tx_pin & !i_other_dom;
endmodule

/* File: tb/crb_rx_buffering_asserts.sv */
// port checker of the can receive buffering block
`timescale 1ns/100ps
module crb_rx_buffering_asserts (
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   // wishbone
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [8:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic        o_wb_ack,
   // pins
   input wire logic        i_bus_receive_pin,
   input wire logic        i_tx_level,
   input wire logic        o_rx_level,
   input wire logic        o_bus_transmit_pin,
   // receive path
   input wire logic        i_rx_sof,
   input wire logic        i_rx_eof_ok,
   input wire logic        i_filter_hit,
   input wire logic        i_transmitting,
   input wire logic        i_arb_lost,
   input wire logic        o_ack_allowed,
   // other outputs
   input wire logic        o_bit_tick,
   input wire logic        o_tx_req,
   input wire logic [1:0]  o_tx_sel,
   input wire logic        o_rx_irq,
   input wire logic        o_ovr_irq
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   logic lb_q;
   logic ie_q;
   logic own_q;
   // request decode
   wire take = i_wb_cyc & i_wb_stb & !o_wb_ack;
   wire ctl_wr = take & i_wb_we & i_wb_sel[0] & (i_wb_adr[8:2] == 7'h00);
   wire acc = i_rx_eof_ok & i_filter_hit & !(own_q & !lb_q);
   // mirror of control bits and own-frame status
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lb_q  <= 1'b0;
         ie_q  <= 1'b0;
         own_q <= 1'b0;
      end else begin
         if (ctl_wr) begin
            lb_q <= i_wb_dat[0];
            ie_q <= i_wb_dat[1];
         end
         if (i_rx_sof) begin
            own_q <= i_transmitting;
         end else if (i_arb_lost) begin
            own_q <= 1'b0;
         end
      end
   end
   sequence s_ack_pulse;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   a_ack_pulse: assert property (take |=> s_ack_pulse)
      else $error("ack missing or too long");
   a_tx_pin: assert property ($past(i_rst_b) |-> o_bus_transmit_pin == $past(i_tx_level))
      else $error("transmit pin not the engine level");
   a_rx_sync: assert property ($past(i_rst_b, 2) && $past(i_rst_b)
      |-> o_rx_level == $past(i_bus_receive_pin, 2))
      else $error("receive level wrong");
   a_tick_gap: assert property (o_bit_tick |=> !o_bit_tick [*8])
      else $error("bit tick too close");
   a_irq_mask: assert property (!ie_q |-> !o_rx_irq)
      else $error("masked receive irq raised");
   a_rx_irq_set: assert property (acc && ie_q && !take |=> o_rx_irq)
      else $error("accepted frame gave no irq");
   a_own_quiet: assert property (i_rx_eof_ok && own_q && !lb_q && ie_q && !o_rx_irq && !take
      |=> !o_rx_irq)
      else $error("own frame raised irq");
   a_own_no_ack: assert property (i_rx_sof && i_transmitting && !lb_q |=> !o_ack_allowed)
      else $error("own frame acknowledged");
   a_ovr_cause: assert property ($rose(o_ovr_irq) |-> $past(i_rx_eof_ok && i_filter_hit) || $past(ctl_wr))
      else $error("overrun without a frame");
   a_tx_sel: assert property (o_tx_req |-> o_tx_sel <= 2'h2)
      else $error("bad transmit select");
endmodule
bind crb_rx_buffering crb_rx_buffering_asserts crb_rx_buffering_asserts_i (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
   .o_wb_ack(o_wb_ack), .i_bus_receive_pin(i_bus_receive_pin), .i_tx_level(i_tx_level),
   .o_rx_level(o_rx_level), .o_bus_transmit_pin(o_bus_transmit_pin), .i_rx_sof(i_rx_sof),
   .i_rx_eof_ok(i_rx_eof_ok), .i_filter_hit(i_filter_hit), .i_transmitting(i_transmitting),
   .i_arb_lost(i_arb_lost), .o_ack_allowed(o_ack_allowed), .o_bit_tick(o_bit_tick),
   .o_tx_req(o_tx_req), .o_tx_sel(o_tx_sel), .o_rx_irq(o_rx_irq), .o_ovr_irq(o_ovr_irq));

/* File: tb/crb_rx_buffering_test.sv */
// self-checking bench of the can receive buffering block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t got %h expected %h", $time, (a), (b)); end end
module crb_rx_buffering_test
   import crb_pkg::*;
;
   logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, rxpin, txpin, rxlvl;
   logic [8:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] wdat = 0, rdat, r;
   logic sof = 0, wr = 0, eof = 0, hit = 0, tmit = 0, arb = 0, ackok, tick;
   crb_idx_t idx = 0, txidx = 0;
   crb_byte_t data = 0, txbyte, v;
   logic txlvl = 1, txdone = 0, txreq, rxirq, ovrirq, dom = 0;
   logic [1:0] txsel;
   logic [7:0] fg [13] = '{default: 8'h00};
   logic [7:0] bg [13] = '{default: 8'h00};
   bit full, pend, ovr, lb, ie, oe;
   int check_count = 0, failures = 0, n;
   crb_rx_buffering crb_rx_buffering_i (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_bus_receive_pin(rxpin),
      .o_bus_transmit_pin(txpin), .i_rx_sof(sof), .i_rx_wr(wr), .i_rx_idx(idx),
      .i_rx_data(data), .i_rx_eof_ok(eof), .i_filter_hit(hit), .i_transmitting(tmit),
      .i_arb_lost(arb), .o_rx_level(rxlvl), .o_ack_allowed(ackok), .o_bit_tick(tick),
      .i_tx_level(txlvl), .i_tx_rd_idx(txidx), .i_tx_done(txdone), .o_tx_req(txreq),
      .o_tx_sel(txsel), .o_tx_byte(txbyte), .o_rx_irq(rxirq), .o_ovr_irq(ovrirq));
   crb_xcvr_model crb_xcvr_model_i (.i_tx_pin(txpin), .o_rx_pin(rxpin), .i_other_dom(dom));
   // free-running clock
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one classic wishbone cycle
   task automatic wbx(input bit w, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         failures++;
         close_out();
      end
   endtask
   task automatic ctl(input bit [2:0] c);
      wbx(1, 9'h000, {29'h0, c});
      {oe, ie, lb} = c;
   endtask
   task automatic clr(input bit [1:0] c);
      wbx(1, 9'h004, {30'h0, c});
      if (c[1]) ovr = 0;
      if (c[0] && pend) begin
         fg = bg;
         pend = 0;
      end else if (c[0]) full = 0;
   endtask
   // one received frame plus reference model update
   task automatic frame(input bit own, input bit fh, input bit lost);
      logic [7:0] b;
      @(posedge clk);
      sof <= 1'b1;
      tmit <= own;
      @(posedge clk);
      sof <= 1'b0;
      for (int i = 0; i < 13; i++) begin
         b = 8'($urandom);
         if (!pend) bg[i] = (i == 12 && b[3:0] > 4'h8) ? {b[7:4], 4'h8} : b;
         @(posedge clk);
         if (i == 12) `CHK(ackok, !(own && !lost && !lb));
         wr <= 1'b1;
         arb <= lost && (i == 0);
         idx <= 4'(i);
         data <= b;
      end
      @(posedge clk);
      wr <= 1'b0;
      eof <= 1'b1;
      hit <= fh;
      @(posedge clk);
      eof <= 1'b0;
      if (fh && !(own && !lost && !lb)) begin
         if (!full) begin
            fg = bg;
            full = 1;
         end else if (!pend) pend = 1;
         else ovr = 1;
      end
   endtask
   task automatic check_rx();
      wbx(0, 9'h004, 0);
      `CHK(r, {30'h0, ovr, full});
      for (int i = 0; i < 13; i++) begin
         wbx(0, 9'(9'h040 + 4 * i), 0);
         `CHK(r, {24'h0, fg[i]});
      end
      `CHK(rxirq, full & ie);
      `CHK(ovrirq, ovr & oe);
   endtask
   logic [8:0] ra [5] = '{9'h000, 9'h004, 9'h008, 9'h00c, 9'h1fc};
   logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h1f4, 32'h7, 32'h0};
   // main sequence
   initial begin
      void'($urandom(32'hf184));
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      wbx(1, 9'h1fc, 32'hff);
      for (int i = 0; i < 5; i++) begin
         wbx(0, ra[i], 0);
         `CHK(r, rv[i]);
      end
      ctl(3'h6);
      @(posedge clk) txlvl <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK({txpin, rxlvl}, 2'h0);
      txlvl <= 1'b1;
      dom <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK({txpin, rxlvl}, 2'h2);
      dom <= 1'b0;
      frame(0, 1, 0);
      check_rx();
      frame(0, 0, 0);
      check_rx();
      frame(0, 1, 0);
      frame(0, 1, 0);
      check_rx();
      v = 8'($urandom);
      wbx(1, 9'h0cc, {24'h0, v});
      wbx(1, 9'h00c, 32'h2);
      `CHK({txreq, txsel}, 3'h5);
      @(posedge clk) txidx <= 4'h3;
      repeat (2) @(posedge clk);
      `CHK(txbyte, v);
      txdone <= 1'b1;
      @(posedge clk) txdone <= 1'b0;
      wbx(0, 9'h00c, 0);
      `CHK({r, txreq}, {32'h7, 1'b0});
      clr(2'h1);
      check_rx();
      clr(2'h3);
      check_rx();
      frame(1, 1, 0);
      check_rx();
      ctl(3'h7);
      frame(1, 1, 0);
      check_rx();
      clr(2'h1);
      ctl(3'h6);
      frame(1, 1, 1);
      check_rx();
      ctl(3'h0);
      check_rx();
      clr(2'h1);
      // divider at the top rate, then below it: both tick every 100 cycles
      for (int k = 0; k < 2; k++) begin
         wbx(1, 9'h008, k ? 32'h10 : 32'h64);
         n = 0;
         while (tick !== 1'b1 && n < 700) begin
            @(posedge clk);
            n++;
         end
         if (n >= 700) begin
            failures++;
            close_out();
         end
         n = 0;
         repeat (300) begin
            @(posedge clk);
            if (tick === 1'b1) n++;
         end
         `CHK(n, 3);
      end
      close_out();
   end
endmodule
